// file: bench/bsram_ctrl_model.sv
// memory controller: makes the input clock pair, drives selects, lanes, address and data
module bsram_ctrl_model (
    input wire logic i_mclk,
    output logic o_kp,
    output logic o_kn,
    output logic o_wsel_n,
    output logic o_rsel_n,
    output logic [1:0] o_lanes_n,
    output logic [bsram_pkg::ADDR_W-1:0] o_addr,
    output logic [bsram_pkg::DATA_W-1:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ph_q = 4'h0;
    initial begin
        o_kp = 1'b0;
        o_kn = 1'b1;
        o_wsel_n = 1'b1;
        o_rsel_n = 1'b1;
        o_lanes_n = 2'h3;
        o_addr = 19'h00000;
        o_wdata = 18'h00000;
    end
    // kp rises at phase 0, kn at phase 8; pins move at phases 4 and 12
    always @(posedge i_mclk) begin
        ph_q <= ph_q + 4'h1;
        o_kp <= ~ph_q[3];
        o_kn <= ph_q[3];
    end
    task automatic wait_ph(input logic [3:0] n);
        do @(posedge i_mclk); while (ph_q !== n);
    endtask
    // released lines show the inverse of their last value
    task automatic do_write(input logic sel_n, input logic [18:0] a, input logic [17:0] w0, w1,
                            input logic [1:0] l0, l1);
        wait_ph(4'hc);
        o_wsel_n <= sel_n;
        o_wdata <= w0;
        o_lanes_n <= l0;
        wait_ph(4'h4);
        o_addr <= a;
        o_wdata <= w1;
        o_lanes_n <= l1;
        wait_ph(4'hc);
        o_wsel_n <= 1'b1;
        o_wdata <= ~w1;
        o_addr <= ~a;
        o_lanes_n <= ~l1;
    endtask
    task automatic do_read(input logic [18:0] a);
        wait_ph(4'hc);
        o_rsel_n <= 1'b0;
        o_addr <= a;
        wait_ph(4'hc);
        o_rsel_n <= 1'b1;
        o_addr <= ~a;
    endtask
endmodule // bsram_ctrl_model

// file: bench/test_burst_two_sram_ports.sv
module test_burst_two_sram_ports;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic kp, kn, wsel_n, rsel_n, o_rdata_oe;
    logic [1:0] lanes_n;
    logic [18:0] addr;
    logic [17:0] wdata, o_rdata;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic ce = 1'b1;
    logic dual_mode = 1'b0;
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    bsram_ctrl_model ctrl (.i_mclk(i_mclk), .o_kp(kp), .o_kn(kn), .o_wsel_n(wsel_n), .o_rsel_n(rsel_n),
        .o_lanes_n(lanes_n), .o_addr(addr), .o_wdata(wdata));
    // in dual mode the output clocks run half a period behind the input clocks
    bsram_top dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(ce), .i_kp(kp), .i_kn(kn),
        .i_cp(dual_mode ? kn : 1'b1), .i_cn(dual_mode ? kp : 1'b1),
        .i_write_port_select_n(wsel_n), .i_read_port_select_n(rsel_n), .i_byte_lane_write_select_n(lanes_n),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_d(input logic [17:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // read a pair and follow the burst word by word
    task automatic rd(input logic [18:0] a, input logic [17:0] e0, e1);
        int n;
        n = 0;
        ctrl.do_read(a);
        while (o_rdata_oe !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
        chk_b(o_rdata_oe, 1'b1);
        tick(4);
        chk_d(o_rdata, e0);
        tick(8);
        chk_d(o_rdata, e1);
        tick(8);
        chk_b(o_rdata_oe, 1'b0);
    endtask
    task automatic t_full();
        ctrl.do_write(1'b0, 19'h00000, 18'h3a5c1, 18'h05a3e, 2'h0, 2'h0);
        ctrl.do_write(1'b0, 19'h7ffff, 18'h1f00f, 18'h2c0d3, 2'h0, 2'h0);
        rd(19'h00000, 18'h3a5c1, 18'h05a3e);
        rd(19'h7ffff, 18'h1f00f, 18'h2c0d3);
        $display("test full done");
    endtask
    task automatic t_lanes();
        ctrl.do_write(1'b0, 19'h00000, 18'h2aaaa, 18'h15555, 2'h2, 2'h1);
        rd(19'h00000, 18'h3a4aa, 18'h1543e);
        $display("test lanes done");
    endtask
    task automatic t_desel();
        ctrl.do_write(1'b1, 19'h7ffff, 18'h00000, 18'h3ffff, 2'h0, 2'h0);
        rd(19'h7ffff, 18'h1f00f, 18'h2c0d3);
        $display("test deselect done");
    endtask
    // freeze the block in mid burst: outputs hold, the burst then completes
    task automatic t_freeze();
        int n;
        n = 0;
        ctrl.do_read(19'h00000);
        while (o_rdata_oe !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
        @(posedge i_mclk);
        ce <= 1'b0;
        tick(14);
        chk_b(o_rdata_oe, 1'b1);
        chk_d(o_rdata, 18'h3a4aa);
        repeat (10) @(posedge i_mclk);
        ce <= 1'b1;
        tick(20);
        chk_d(o_rdata, 18'h1543e);
        chk_b(o_rdata_oe, 1'b0);
        $display("test freeze done");
    endtask
    // second reset with running output clocks: the strap selects dual clock mode
    task automatic t_dual();
        @(posedge i_mclk);
        i_arst_n <= 1'b0;
        dual_mode <= 1'b1;
        tick(20);
        chk_b(o_rdata_oe, 1'b0);
        chk_d(o_rdata, 18'h00000);
        @(posedge i_mclk);
        i_arst_n <= 1'b1;
        tick(8);
        rd(19'h7ffff, 18'h1f00f, 18'h2c0d3);
        $display("test dual clock done");
    endtask
    initial begin
        tick(10);
        chk_b(o_rdata_oe, 1'b0);
        chk_d(o_rdata, 18'h00000);
        repeat (10) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        tick(8);
        t_full();
        t_lanes();
        t_desel();
        t_freeze();
        t_dual();
        close_out();
    end
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end
endmodule // test_burst_two_sram_ports

// file: logic/bsram_edge.sv
// samples an outside clock through two flip-flops and reports its rising edge
module bsram_edge (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_pin,
    output logic o_rise,
    output logic o_level
);
    logic s1_q, s1_d;
    logic s2_q, s2_d;
    logic s3_q, s3_d;
    logic [1:0] fill_q, fill_d;

    // edges are masked until the chain holds real pin samples, so a pin idling high gives no false edge
    always_comb begin
        s1_d = i_pin;
        s2_d = s1_q;
        s3_d = s2_q;
        fill_d = (fill_q == 2'h3) ? fill_q : 2'(fill_q + 2'h1);
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            fill_q <= 2'h0;
        end else if (i_ce) begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            fill_q <= fill_d;
        end
    end

    assign o_rise = i_ce & (fill_q == 2'h3) & s2_q & ~s3_q;
    assign o_level = s2_q;
endmodule // bsram_edge

// file: logic/bsram_pkg.sv
package bsram_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 18;
    localparam int LANE0_LSB = 0;
    localparam int LANE0_MSB = 8;
    localparam int LANE1_LSB = 9;
    localparam int LANE1_MSB = 17;
    localparam int LANES = 2;
    localparam int SYNC_STAGES = 2;
    localparam logic [17:0] RST_DATA = 18'h00000;
    localparam logic [18:0] RST_ADDR = 19'h00000;
endpackage

// file: logic/bsram_top.sv
// What this block does
// R1 - write data is taken at both input clock rises during a write
// R2 - active-low write select sampled at positive clock rise starts a write
// R3 - write select high deselects write port, write data ignored
// R4 - byte lane selects sampled at both input clock rises, per data word
// R5 - lane0 bits 8:0, lane1 bits 17:9; unselected lane keeps contents
// R6 - read address sampled at positive input clock rise on shared pins
// R7 - 19-bit address selects a pair of 18-bit words
// R8 - address ignored for a deselected port
// R9 - read data driven at output clock rises, or input clocks in single mode
// R10 - read data outputs not driven while read port deselected
// R11 - active-low read select sampled at positive clock rise starts a read
// R12 - deselect lets pending read finish, then outputs released
// R13 - each read returns two sequential 18-bit words
// R14 - all accesses begin at positive input clock rise
// R15 - negative input clock rise captures inputs, launches data in single mode
// R16 - write address and second word taken at next negative clock rise
// R17 - first write word taken at the positive rise that starts the write
// R18 - low word follows the first positive output rise after the next positive input rise, high word next negative
// R19 - both output clocks held high from reset select single clock mode
// R20 - controller asserts both lane selects to write a full word
module bsram_top #(
    parameter int ADDR_W = bsram_pkg::ADDR_W,
    parameter int DATA_W = bsram_pkg::DATA_W
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_kp,
    input wire logic i_kn,
    input wire logic i_cp,
    input wire logic i_cn,
    input wire logic i_write_port_select_n,
    input wire logic i_read_port_select_n,
    input wire logic [1:0] i_byte_lane_write_select_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rdata_oe
);
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_WAIT = 3'b010,
        RD_HIGH = 3'b100
    } bsram_rd_type;

    logic [DATA_W-1:0] mem_lo [2**ADDR_W];
    logic [DATA_W-1:0] mem_hi [2**ADDR_W];

    logic rst_s1_q, rst_n_q;
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    logic kp_rise, kn_rise, cp_rise, cn_rise, cp_lvl, cn_lvl;
    bsram_edge u_kp (.i_mclk(i_mclk), .i_rst_n(rst_n_q), .i_ce(i_ce), .i_pin(i_kp), .o_rise(kp_rise), .o_level());
    bsram_edge u_kn (.i_mclk(i_mclk), .i_rst_n(rst_n_q), .i_ce(i_ce), .i_pin(i_kn), .o_rise(kn_rise), .o_level());
    bsram_edge u_cp (.i_mclk(i_mclk), .i_rst_n(rst_n_q), .i_ce(i_ce), .i_pin(i_cp), .o_rise(cp_rise),
        .o_level(cp_lvl));
    bsram_edge u_cn (.i_mclk(i_mclk), .i_rst_n(rst_n_q), .i_ce(i_ce), .i_pin(i_cn), .o_rise(cn_rise),
        .o_level(cn_lvl));

    // synchronise the remaining pins
    logic [ADDR_W+DATA_W+3:0] pin_s1_q, pin_s2_q;
    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
        end else if (i_ce) begin
            pin_s1_q <= {i_write_port_select_n, i_read_port_select_n, i_byte_lane_write_select_n, i_addr, i_wdata};
            pin_s2_q <= pin_s1_q;
        end
    end
    logic wps_n, rps_n;
    logic [1:0] bws_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    assign {wps_n, rps_n, bws_n, addr, wdata} = pin_s2_q;

    // strap: single clock mode caught once, after the output clock synchronisers have filled
    logic [1:0] strap_cnt_q, strap_cnt_d;
    logic single_q, single_d;
    always_comb begin
        strap_cnt_d = (strap_cnt_q == 2'h3) ? strap_cnt_q : 2'(strap_cnt_q + 2'h1);
        single_d = (strap_cnt_q == 2'h2) ? (cp_lvl & cn_lvl) : single_q; // R19
    end
    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strap_cnt_q <= 2'h0;
            single_q <= 1'b0;
        end else if (i_ce) begin
            strap_cnt_q <= strap_cnt_d;
            single_q <= single_d;
        end
    end
    logic out_p, out_n;
    assign out_p = single_q ? kp_rise : cp_rise; // R9 R15
    assign out_n = single_q ? kn_rise : cn_rise; // R9 R15

    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w, input logic [DATA_W-1:0] new_w,
        input logic [1:0] sel_n);
        logic [DATA_W-1:0] r;
        r = old_w;
        if (!sel_n[0]) r[bsram_pkg::LANE0_MSB:bsram_pkg::LANE0_LSB] = new_w[bsram_pkg::LANE0_MSB:bsram_pkg::LANE0_LSB];
        if (!sel_n[1]) r[bsram_pkg::LANE1_MSB:bsram_pkg::LANE1_LSB] = new_w[bsram_pkg::LANE1_MSB:bsram_pkg::LANE1_LSB];
        return r;
    endfunction

    // write port
    logic wr_pend_q, wr_pend_d;
    logic [DATA_W-1:0] w0_q, w0_d;
    logic [1:0] b0_q, b0_d;
    logic wr_commit;
    always_comb begin
        wr_pend_d = wr_pend_q;
        w0_d = w0_q;
        b0_d = b0_q;
        wr_commit = 1'b0;
        if (kn_rise && wr_pend_q) begin // R16
            wr_commit = 1'b1;
            wr_pend_d = 1'b0;
        end
        if (kp_rise) begin // R14
            wr_pend_d = !wps_n; // R2 R3
            if (!wps_n) begin
                w0_d = wdata; // R17 R1
                b0_d = bws_n; // R4
            end
        end
    end
    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_pend_q <= 1'b0;
            w0_q <= bsram_pkg::RST_DATA;
            b0_q <= 2'h3;
        end else if (i_ce) begin
            wr_pend_q <= wr_pend_d;
            w0_q <= w0_d;
            b0_q <= b0_d;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_ce && wr_commit) begin // R7 R16
            mem_lo[addr] <= lane_merge(mem_lo[addr], w0_q, b0_q); // R5
            mem_hi[addr] <= lane_merge(mem_hi[addr], wdata, bws_n); // R1 R4 R5
        end
    end

    // read port
    bsram_rd_type rd_q, rd_d;
    logic [ADDR_W-1:0] ra_q, ra_d;
    logic [DATA_W-1:0] q_q, q_d;
    logic oe_q, oe_d;
    logic start_q, start_d;
    always_comb begin
        rd_d = rd_q;
        ra_d = ra_q;
        q_d = q_q;
        oe_d = oe_q;
        start_d = start_q;
        if (kp_rise) begin
            start_d = !rps_n; // R11
            if (!rps_n) ra_d = addr; // R6 R8
        end
        unique case (rd_q)
            RD_IDLE: begin
                if (kp_rise && start_q) rd_d = RD_WAIT; // R18
            end
            RD_WAIT: begin
                if (out_p) begin
                    q_d = mem_lo[ra_q]; // R13 R18
                    oe_d = 1'b1;
                    rd_d = RD_HIGH;
                end
            end
            RD_HIGH: begin
                if (out_n) begin
                    q_d = mem_hi[ra_q]; // R13 R18
                    rd_d = RD_IDLE;
                end
            end
        endcase
        if (out_p && rd_q != RD_WAIT && oe_q) oe_d = 1'b0; // R10 R12
    end
    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_q <= RD_IDLE;
            ra_q <= bsram_pkg::RST_ADDR;
            q_q <= bsram_pkg::RST_DATA;
            oe_q <= 1'b0;
            start_q <= 1'b0;
        end else if (i_ce) begin
            rd_q <= rd_d;
            ra_q <= ra_d;
            q_q <= q_d;
            oe_q <= oe_d;
            start_q <= start_d;
        end
    end
    assign o_rdata = q_q; // R9
    assign o_rdata_oe = oe_q; // R10

    property p_wr_needs_start;
        @(posedge i_mclk) disable iff (!rst_n_q) wr_commit |-> wr_pend_q;
    endproperty
    a_wr_needs_start: assert property (p_wr_needs_start) else $error("write without start"); // R2
    property p_oe_off_idle;
        @(posedge i_mclk) disable iff (!rst_n_q) (i_ce && rd_q == RD_IDLE && out_p) |=> !oe_q;
    endproperty
    a_oe_off_idle: assert property (p_oe_off_idle) else $error("outputs not released"); // R10
    property p_hi_after_lo;
        @(posedge i_mclk) disable iff (!rst_n_q) (i_ce && rd_q == RD_WAIT && out_p) |=> (rd_q == RD_HIGH && oe_q);
    endproperty
    a_hi_after_lo: assert property (p_hi_after_lo) else $error("burst sequence broken"); // R13
    property p_commit_on_kn;
        @(posedge i_mclk) disable iff (!rst_n_q) wr_commit |-> kn_rise;
    endproperty
    a_commit_on_kn: assert property (p_commit_on_kn) else $error("write stored off the negative rise"); // R16
    property p_desel_drops;
        @(posedge i_mclk) disable iff (!rst_n_q) (kp_rise && wps_n) |=> !wr_pend_q;
    endproperty
    a_desel_drops: assert property (p_desel_drops) else $error("deselected write still pending"); // R3
    property p_oe_stays_off;
        @(posedge i_mclk) disable iff (!rst_n_q) (!oe_q && rd_q != RD_WAIT) |=> !oe_q;
    endproperty
    a_oe_stays_off: assert property (p_oe_stays_off) else $error("outputs driven outside a burst"); // R10
endmodule // bsram_top
